//--- cic_pkg.sv
// Contract
// - after reset vector spacing is one byte per entry until software writes it
// - detect, merge and steer each interrupt input onto the fast or normal request
// - every input is treated as a pulse; each detected pulse sets its flag
// - a held cross-core level source looks like repeated pulses
// - one flag per interrupt, no pulse counting, repeats while set do nothing
// - a set flag stays until software clears it through the controller
// - clearing a flag while a level source is held sets it again
package cic_pkg;
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned NUM_SRC         = 8;
  localparam int unsigned NUM_SIG         = 4;
  // register word offsets
  localparam logic [3:0] OFS_FLAG         = 4'h0;  // sticky flags, write one to clear
  localparam logic [3:0] OFS_ENABLE       = 4'h1;  // per-source enable (mask)
  localparam logic [3:0] OFS_STEER        = 4'h2;  // 1 = fast request, 0 = normal
  localparam logic [3:0] OFS_VSPACE       = 4'h3;  // vector_spacing_reg
  localparam logic [3:0] OFS_VBASE        = 4'h4;  // vector table base
  localparam logic [3:0] OFS_NORM_VEC     = 4'h5;  // vector of highest pending normal source
  localparam logic [3:0] OFS_FAST_VEC     = 4'h6;  // vector of highest pending fast source
  localparam logic [3:0] OFS_SIG_STATUS   = 4'h7;  // soft_signal_status_reg, write one sets
  localparam logic [3:0] OFS_SIG_CLEAR    = 4'h8;  // soft_signal_clear_reg
  // vector spacing encodings, bytes per entry = 1 << code
  localparam logic [1:0] VSPACE_BYTE1     = 2'h0;
  localparam logic [1:0] VSPACE_BYTE4     = 2'h2;
  localparam logic [1:0] VSPACE_RESET     = VSPACE_BYTE1;
  localparam logic [31:0] VBASE_RESET     = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  typedef enum logic [1:0] {
    CIC_IDLE   = 2'b00,
    CIC_FIRST  = 2'b01,
    CIC_HELD   = 2'b11
  } cic_edge_type;
endpackage : cic_pkg

//--- cic_pulse_detect.sv
`timescale 1ns/1ps
// pulse detector per input: a held level keeps yielding pulses
module cic_pulse_detect #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] src,
  output logic      [WIDTH-1:0] pulse
);
  cic_pkg::cic_edge_type state [WIDTH];
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_det
      // alternate pulse phases while the input is high
      always_ff @(posedge clock) begin
        if (rst) begin
          state[i] <= cic_pkg::CIC_IDLE;
        end else if (!src[i]) begin
          state[i] <= cic_pkg::CIC_IDLE;
        end else begin
          unique case (state[i])
            cic_pkg::CIC_IDLE:  state[i] <= cic_pkg::CIC_FIRST;
            cic_pkg::CIC_FIRST: state[i] <= cic_pkg::CIC_HELD;
            cic_pkg::CIC_HELD:  state[i] <= cic_pkg::CIC_FIRST;
            default:            state[i] <= cic_pkg::CIC_IDLE;
          endcase
        end
      end
      // a held level re-pulses every second cycle
      assign pulse[i] = src[i] && (state[i] != cic_pkg::CIC_FIRST);
    end
  endgenerate

  a_held_repulse: assert property (@(posedge clock) disable iff (rst)
    src[0] && $past(src[0]) && !pulse[0] |=> src[0] |-> pulse[0])
    else $error("held level did not pulse again");
endmodule : cic_pulse_detect

//--- cic_prio_enc.sv
`timescale 1ns/1ps
// lowest-index set bit wins
module cic_prio_enc #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned IDX_W = 3
) (
  input  wire logic [WIDTH-1:0] req,
  output logic                  found,
  output logic      [IDX_W-1:0] index
);
  // scan from the top so the lowest index is left standing
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int k = WIDTH - 1; k >= 0; k--) begin
      if (req[k]) begin
        found = 1'b1;
        index = IDX_W'(k);
      end
    end
  end
endmodule : cic_prio_enc

//--- cic_core_irq_controller.sv
`timescale 1ns/1ps
// core_irq_controller: flags, steering, vectors, soft signal flags
module cic_core_irq_controller #(
  parameter int unsigned NUM_SRC = cic_pkg::NUM_SRC,
  parameter int unsigned NUM_SIG = cic_pkg::NUM_SIG
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [NUM_SRC-NUM_SIG-1:0] sys_irq,
  input  wire logic [cic_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [31:0]                rdata,
  output logic                            fiq,
  output logic                            irq
);
  localparam int unsigned IDX_W = $clog2(NUM_SRC);

  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] steer;
  logic [1:0]         vspace;
  logic [31:0]        vbase;
  logic [NUM_SIG-1:0] sig_flag;
  logic [NUM_SRC-1:0] pulse;
  logic [NUM_SRC-1:0] pend;
  logic               fast_found;
  logic               norm_found;
  logic [IDX_W-1:0]   fast_idx;
  logic [IDX_W-1:0]   norm_idx;
  logic [31:0]        next_rdata;

  // vector address from base, index and spacing
  function automatic logic [31:0] vec_addr(input logic [IDX_W-1:0] idx,
                                           input logic [1:0] sp,
                                           input logic [31:0] base);
    logic [31:0] off;
    off = 32'(idx) << sp;
    return base + off;
  endfunction : vec_addr

  function automatic logic hit(input logic [cic_pkg::ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : hit

  // cross-core sources sit above the plain system inputs
  cic_pulse_detect #(.WIDTH(NUM_SRC)) u_detect (
    .clock (clock),
    .rst   (rst),
    .src   ({sig_flag, sys_irq}),
    .pulse (pulse)
  );

  // sticky single flag, set beats write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~((wr && hit(cic_pkg::OFS_FLAG)) ? wdata[NUM_SRC-1:0] : '0)) | pulse;
    end
  end

  // software control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      enable <= '0;
      steer  <= '0;
      vspace <= cic_pkg::VSPACE_RESET; // one byte per entry until written
      vbase  <= cic_pkg::VBASE_RESET;
    end else if (wr) begin
      if (hit(cic_pkg::OFS_ENABLE)) enable <= wdata[NUM_SRC-1:0];
      if (hit(cic_pkg::OFS_STEER))  steer  <= wdata[NUM_SRC-1:0];
      if (hit(cic_pkg::OFS_VSPACE)) vspace <= wdata[1:0];
      if (hit(cic_pkg::OFS_VBASE))  vbase  <= wdata;
    end
  end

  // soft signal flags: write one sets via status, write one clears via clear
  always_ff @(posedge clock) begin
    if (rst) begin
      sig_flag <= '0;
    end else if (wr && hit(cic_pkg::OFS_SIG_CLEAR)) begin
      sig_flag <= sig_flag & ~wdata[NUM_SIG-1:0];
    end else if (wr && hit(cic_pkg::OFS_SIG_STATUS)) begin
      sig_flag <= sig_flag | wdata[NUM_SIG-1:0];
    end
  end

  // merge enabled flags and steer to the two request lines
  assign pend = flag & enable;
  cic_prio_enc #(.WIDTH(NUM_SRC), .IDX_W(IDX_W)) u_fast (
    .req   (pend & steer),
    .found (fast_found),
    .index (fast_idx)
  );
  cic_prio_enc #(.WIDTH(NUM_SRC), .IDX_W(IDX_W)) u_norm (
    .req   (pend & ~steer),
    .found (norm_found),
    .index (norm_idx)
  );

  // request outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      fiq <= 1'b0;
      irq <= 1'b0;
    end else begin
      fiq <= fast_found;
      irq <= norm_found;
    end
  end

  // read mux, zero for unmapped offsets
  always_comb begin
    next_rdata = cic_pkg::ZERO_WORD;
    unique case (addr)
      cic_pkg::OFS_FLAG:       next_rdata[NUM_SRC-1:0] = flag;
      cic_pkg::OFS_ENABLE:     next_rdata[NUM_SRC-1:0] = enable;
      cic_pkg::OFS_STEER:      next_rdata[NUM_SRC-1:0] = steer;
      cic_pkg::OFS_VSPACE:     next_rdata[1:0]         = vspace;
      cic_pkg::OFS_VBASE:      next_rdata              = vbase;
      cic_pkg::OFS_NORM_VEC:   next_rdata = vec_addr(norm_idx, vspace, vbase);
      cic_pkg::OFS_FAST_VEC:   next_rdata = vec_addr(fast_idx, vspace, vbase);
      cic_pkg::OFS_SIG_STATUS: next_rdata[NUM_SIG-1:0] = sig_flag; // bit 0 is signal 0
      default:                 next_rdata = cic_pkg::ZERO_WORD;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= cic_pkg::ZERO_WORD;
    end else begin
      rdata <= rd ? next_rdata : cic_pkg::ZERO_WORD;
    end
  end

  // decoded write strobes, read only by the checks below
  logic wr_flag;
  logic wr_enable;
  logic wr_steer;
  logic wr_vspace;
  logic wr_vbase;
  logic wr_sig_set;
  logic wr_sig_clr;
  assign wr_flag    = wr && (addr == cic_pkg::OFS_FLAG);
  assign wr_enable  = wr && (addr == cic_pkg::OFS_ENABLE);
  assign wr_steer   = wr && (addr == cic_pkg::OFS_STEER);
  assign wr_vspace  = wr && (addr == cic_pkg::OFS_VSPACE);
  assign wr_vbase   = wr && (addr == cic_pkg::OFS_VBASE);
  assign wr_sig_set = wr && (addr == cic_pkg::OFS_SIG_STATUS);
  assign wr_sig_clr = wr && (addr == cic_pkg::OFS_SIG_CLEAR);

  a_vspace_reset: assert property (@(posedge clock)
    $fell(rst) |-> vspace == cic_pkg::VSPACE_BYTE1)
    else $error("spacing not one byte after reset");
  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    flag[0] && !(wr && hit(cic_pkg::OFS_FLAG) && wdata[0]) |=> flag[0])
    else $error("flag dropped without clear");
  a_pulse_sets: assert property (@(posedge clock) disable iff (rst)
    pulse[1] |=> flag[1])
    else $error("pulse did not set flag");
  a_set_wins: assert property (@(posedge clock) disable iff (rst)
    pulse[0] && wr && hit(cic_pkg::OFS_FLAG) && wdata[0] |=> flag[0])
    else $error("clear beat a pulse");
  a_level_reset: assert property (@(posedge clock) disable iff (rst)
    sig_flag[0] ##1 (wr && hit(cic_pkg::OFS_FLAG) && wdata[NUM_SRC-NUM_SIG] && sig_flag[0]
    && !(wr && hit(cic_pkg::OFS_SIG_CLEAR))) |-> ##[1:3] flag[NUM_SRC-NUM_SIG])
    else $error("held level did not set flag again");
  a_sig_clear: assert property (@(posedge clock) disable iff (rst)
    wr && hit(cic_pkg::OFS_SIG_CLEAR) && wdata[0] |=> !sig_flag[0])
    else $error("soft signal not cleared");
  a_fast_route: assert property (@(posedge clock) disable iff (rst)
    |(flag & enable & steer) |=> fiq)
    else $error("fast request missing");
  a_norm_route: assert property (@(posedge clock) disable iff (rst)
    !(|(flag & enable & ~steer)) |=> !irq)
    else $error("normal request without cause");
  a_read_slot: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == cic_pkg::ZERO_WORD)
    else $error("read data outside its slot");

  // outputs quiet right after a reset edge
  a_reset_quiet: assert property (@(posedge clock)
    rst |=> !fiq && !irq && rdata == cic_pkg::ZERO_WORD)
    else $error("outputs not quiet after reset");

  // no flag survives a reset edge
  a_reset_flags: assert property (@(posedge clock)
    rst |=> flag == '0 && sig_flag == '0)
    else $error("flags not cleared by reset");

  // mask and steering cleared by reset
  a_reset_mask: assert property (@(posedge clock)
    rst |=> enable == '0 && steer == '0)
    else $error("mask or steering not cleared by reset");

  // table base back at its reset value
  a_base_reset: assert property (@(posedge clock)
    rst |=> vbase == cic_pkg::VBASE_RESET)
    else $error("vector base not reset");

  // spacing keeps its code until software writes it
  a_spacing_held: assert property (@(posedge clock) disable iff (rst)
    !wr_vspace |=> $stable(vspace))
    else $error("spacing changed without a write");

  // spacing write lands at the strobe edge
  a_spacing_write: assert property (@(posedge clock) disable iff (rst)
    wr_vspace |=> vspace == $past(wdata[1:0]))
    else $error("spacing write lost");

  // mask write lands
  a_enable_write: assert property (@(posedge clock) disable iff (rst)
    wr_enable |=> enable == $past(wdata[NUM_SRC-1:0]))
    else $error("mask write lost");

  // steering write lands
  a_steer_write: assert property (@(posedge clock) disable iff (rst)
    wr_steer |=> steer == $past(wdata[NUM_SRC-1:0]))
    else $error("steering write lost");

  // base write lands
  a_base_write: assert property (@(posedge clock) disable iff (rst)
    wr_vbase |=> vbase == $past(wdata))
    else $error("vector base write lost");

  // mask holds between writes
  a_mask_held: assert property (@(posedge clock) disable iff (rst)
    !wr_enable |=> $stable(enable))
    else $error("mask changed without a write");

  // steering holds between writes
  a_steer_held: assert property (@(posedge clock) disable iff (rst)
    !wr_steer |=> $stable(steer))
    else $error("steering changed without a write");

  // write one to status sets soft signal flags
  a_sig_set: assert property (@(posedge clock) disable iff (rst)
    wr_sig_set |=> sig_flag == ($past(sig_flag) | $past(wdata[NUM_SIG-1:0])))
    else $error("soft signal set lost");

  // soft signal flags hold without a write
  a_sig_held: assert property (@(posedge clock) disable iff (rst)
    !wr_sig_set && !wr_sig_clr |=> $stable(sig_flag))
    else $error("soft signal changed without a write");

  // a rising soft signal level pulses its source at once
  a_sig_source: assert property (@(posedge clock) disable iff (rst)
    sig_flag[0] && !$past(sig_flag[0]) |-> pulse[NUM_SRC-NUM_SIG])
    else $error("cross-core level gave no pulse");

  // per source flag checks
  for (genvar j = 0; j < NUM_SRC; j++) begin : g_flag_chk

    // no flag rises without a pulse
    a_flag_idle: assert property (@(posedge clock) disable iff (rst)
      !flag[j] && !pulse[j] |=> !flag[j])
      else $error("flag set without a pulse");

    // write one clears when no pulse competes
    a_clear_drops: assert property (@(posedge clock) disable iff (rst)
      flag[j] && wr_flag && wdata[j] && !pulse[j] |=> !flag[j])
      else $error("flag not cleared by write one");

    // every pulse leaves its flag set
    a_pulse_marks: assert property (@(posedge clock) disable iff (rst)
      pulse[j] |=> flag[j])
      else $error("pulse did not mark its flag");

    // repeats on a set flag change nothing
    a_repeat_none: assert property (@(posedge clock) disable iff (rst)
      flag[j] && pulse[j] |=> flag[j])
      else $error("repeated pulse disturbed flag");
  end

  // fast line only with a fast cause
  a_fiq_cause: assert property (@(posedge clock) disable iff (rst)
    !(|(flag & enable & steer)) |=> !fiq)
    else $error("fast request without cause");

  // normal line follows a normal cause
  a_irq_cause: assert property (@(posedge clock) disable iff (rst)
    |(flag & enable & ~steer) |=> irq)
    else $error("normal request missing");

  // masked flags raise neither line
  a_mask_blocks: assert property (@(posedge clock) disable iff (rst)
    (flag & enable) == '0 |=> !fiq && !irq)
    else $error("request with every flag masked");

  // flag read returns the flags of the strobe cycle
  a_read_flag: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_FLAG |=> rdata[NUM_SRC-1:0] == $past(flag))
    else $error("flag read wrong");

  // mask read back
  a_read_enable: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_ENABLE |=> rdata[NUM_SRC-1:0] == $past(enable))
    else $error("mask read wrong");

  // steering read back
  a_read_steer: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_STEER |=> rdata[NUM_SRC-1:0] == $past(steer))
    else $error("steering read wrong");

  // spacing read back
  a_read_spacing: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_VSPACE |=> rdata == 32'($past(vspace)))
    else $error("spacing read wrong");

  // base read back
  a_read_base: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_VBASE |=> rdata == $past(vbase))
    else $error("vector base read wrong");

  // status read shows the soft signal flags
  a_read_status: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_SIG_STATUS |=> rdata[NUM_SIG-1:0] == $past(sig_flag))
    else $error("soft signal status read wrong");

  // clear register and unmapped offsets read zero
  a_read_unmapped: assert property (@(posedge clock) disable iff (rst)
    rd && addr >= cic_pkg::OFS_SIG_CLEAR |=> rdata == cic_pkg::ZERO_WORD)
    else $error("unmapped read not zero");

  // one byte per entry before spacing is written
  a_vec_one_byte: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_NORM_VEC && vspace == cic_pkg::VSPACE_BYTE1
    |=> rdata == $past(vbase) + 32'($past(norm_idx)))
    else $error("one byte vector wrong");

  // four bytes per entry once programmed
  a_vec_four_byte: assert property (@(posedge clock) disable iff (rst)
    rd && addr == cic_pkg::OFS_FAST_VEC && vspace == cic_pkg::VSPACE_BYTE4
    |=> rdata == $past(vbase) + (32'($past(fast_idx)) << 2))
    else $error("four byte vector wrong");

  c_fast_req: cover property (@(posedge clock) disable iff (rst) $rose(fiq));
  c_norm_req: cover property (@(posedge clock) disable iff (rst) $rose(irq));
  c_spurious: cover property (@(posedge clock) disable iff (rst)
    $fell(flag[NUM_SRC-NUM_SIG]) ##[1:3] flag[NUM_SRC-NUM_SIG]);
  c_spacing4: cover property (@(posedge clock) disable iff (rst)
    vspace == cic_pkg::VSPACE_BYTE4);
endmodule : cic_core_irq_controller

//--- cic_core_model.sv
`timescale 1ns/1ps
// core side: counts each entry into the normal and fast handlers
module cic_core_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       fiq,
  input  wire logic       irq,
  output logic      [7:0] fiq_entries,
  output logic      [7:0] irq_entries
);
  logic fiq_prev;
  logic irq_prev;
  // a handler is entered once per rising request; software clears the cause
  always_ff @(posedge clock) begin
    fiq_prev <= rst ? 1'b0 : fiq;
    irq_prev <= rst ? 1'b0 : irq;
    if (rst) begin
      fiq_entries <= 8'h00;
      irq_entries <= 8'h00;
    end else begin
      fiq_entries <= fiq_entries + 8'((fiq && !fiq_prev) ? 1 : 0);
      irq_entries <= irq_entries + 8'((irq && !irq_prev) ? 1 : 0);
    end
  end
endmodule : cic_core_model

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end
module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sys_irq = 4'h0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        fiq;
  logic        irq;
  logic [7:0]  fiq_entries;
  logic [7:0]  irq_entries;
  logic        rd_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_w;
  logic [31:0] seed = 32'd68;
  logic [31:0] base;
  logic [7:0]  n;
  logic [3:0]  m;
  int          num_errors = 0;
  int          check_count = 0;
  always #12.5 clock = ~clock;
  cic_core_irq_controller cic_core_irq_controller_inst (.clock(clock), .rst(rst),
    .sys_irq(sys_irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fiq(fiq), .irq(irq));
  cic_core_model cic_core_model_inst (.clock(clock), .rst(rst), .fiq(fiq), .irq(irq),
    .fiq_entries(fiq_entries), .irq_entries(irq_entries));
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg
  // read strobe; the expected word waits in the queue for the monitor
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd   <= 1'b0;
  endtask : rd_reg
  task automatic pulse(input logic [3:0] p, input int len);
    @(posedge clock);
    sys_irq <= p;
    repeat (len) @(posedge clock);
    sys_irq <= 4'h0;
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) begin
      exp_w = exp_q.pop_front();
      `CHK("rdata", exp_w, rdata)
    end
    rd_d <= rd;
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd_reg((i == 9) ? 4'hf : 4'(i), 32'h0);
    $display("test reset done");
    base = xorshift() & 32'hffff_ff00;
    wr_reg(cic_pkg::OFS_ENABLE, 32'hff);
    wr_reg(cic_pkg::OFS_VBASE, base);
    pulse(4'h4, 1);
    rd_reg(cic_pkg::OFS_NORM_VEC, base + 32'h2);
    wr_reg(cic_pkg::OFS_VSPACE, 32'(cic_pkg::VSPACE_BYTE4));
    rd_reg(cic_pkg::OFS_NORM_VEC, base + 32'h8);
    wr_reg(cic_pkg::OFS_STEER, 32'h2);
    pulse(4'h2, 1);
    `CHK("fiq", 1'b1, fiq)
    `CHK("irq", 1'b1, irq)
    rd_reg(cic_pkg::OFS_FAST_VEC, base + 32'h4);
    `CHK("fiq_entries", 8'h1, fiq_entries)
    wr_reg(cic_pkg::OFS_FLAG, 32'hff);
    repeat (3) @(posedge clock);
    `CHK("fiq", 1'b0, fiq)
    `CHK("irq", 1'b0, irq)
    $display("test vectors and steering done");
    n = irq_entries;
    pulse(4'h1, 7);
    rd_reg(cic_pkg::OFS_FLAG, 32'h1);
    `CHK("irq_entries", n + 8'h1, irq_entries)
    wr_reg(cic_pkg::OFS_FLAG, 32'h1);
    rd_reg(cic_pkg::OFS_FLAG, 32'h0);
    pulse(4'h8, 1);
    wr_reg(cic_pkg::OFS_ENABLE, 32'hf7);
    repeat (3) @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    wr_reg(cic_pkg::OFS_ENABLE, 32'hff);
    repeat (3) @(posedge clock);
    `CHK("irq unmasked", 1'b1, irq)
    wr_reg(cic_pkg::OFS_FLAG, 32'hff);
    $display("test held level and mask done");
    wr_reg(cic_pkg::OFS_SIG_STATUS, 32'h1);
    repeat (3) @(posedge clock);
    rd_reg(cic_pkg::OFS_FLAG, 32'h10);
    wr_reg(cic_pkg::OFS_FLAG, 32'h10);
    repeat (3) @(posedge clock);
    rd_reg(cic_pkg::OFS_FLAG, 32'h10);
    rd_reg(cic_pkg::OFS_SIG_STATUS, 32'h1);
    wr_reg(cic_pkg::OFS_SIG_CLEAR, 32'h1);
    rd_reg(cic_pkg::OFS_SIG_STATUS, 32'h0);
    wr_reg(cic_pkg::OFS_FLAG, 32'h10);
    repeat (3) @(posedge clock);
    rd_reg(cic_pkg::OFS_FLAG, 32'h0);
    `CHK("irq", 1'b0, irq)
    $display("test cross-core done");
    for (int k = 0; k < 6; k++) begin
      m = 4'(xorshift());
      pulse(m, 1 + k % 3);
      rd_reg(cic_pkg::OFS_FLAG, {28'h0, m});
      wr_reg(cic_pkg::OFS_FLAG, 32'hff);
    end
    $display("test random pulses done");
    repeat (3) @(posedge clock);
    print_verdict();
  end
endmodule : tb
